// ### verilog/pcs_program_counter_sequencer.v
/*
 * Program counter sequencer: holds the 11-bit fetch address and
 * selects its next value once per accepted instruction step.
 * Assumes the decoder presents op, length, immediates and the branch
 * condition flag in the same cycle as i_step, and that the return
 * stack supplies the popped address combinationally with i_step.
 */
`timescale 1ns/10ps
`include "pcs_defines.vh"

module pcs_program_counter_sequencer
#(
    parameter PC_WIDTH = `PCS_PC_WIDTH
)
(
    input wire i_ref_clk,
    input wire i_resetn,
    input wire i_step,
    input wire [2:0] i_op,
    input wire [1:0] i_instr_len,
    input wire i_branch_condition_flag,
    input wire [PC_WIDTH-1:0] i_imm_addr,
    input wire [`PCS_SCALL_BITS-1:0] i_short_call_imm,
    input wire [`PCS_VECTOR_WIDTH-1:0] i_int_vector,
    input wire [PC_WIDTH-1:0] i_stack_addr,
    output wire [PC_WIDTH-1:0] o_fetch_addr,
    output wire o_push,
    output wire o_push_flags,
    output wire [PC_WIDTH-1:0] o_push_addr,
    output wire o_pop
);

    // ========================================================
    // Helpers
    // ========================================================
    // Counter arithmetic wraps modulo the address space
    function [PC_WIDTH-1:0] add_len;
        input [PC_WIDTH-1:0] base;
        input [PC_WIDTH-1:0] len;
        begin
            add_len = base + len;
        end
    endfunction

    // Decode of the op field shared by the stack strobes and the push address select
    function op_is;
        input [2:0] op;
        input [2:0] code;
        begin
            op_is = (op == code);
        end
    endfunction

    // Joins a page number with the six-bit in-page offset
    function [PC_WIDTH-1:0] page_join;
        input [`PCS_PAGE_BITS-1:0] page;
        input [PC_WIDTH-1:0] imm;
        begin
            page_join = {page, imm[`PCS_SHORT_BITS-1:0]};
        end
    endfunction

    // ========================================================
    // State and candidate addresses
    // ========================================================
    reg [PC_WIDTH-1:0] program_counter;
    reg [PC_WIDTH-1:0] next_program_counter;
    wire [PC_WIDTH-1:0] len_ext;
    wire [PC_WIDTH-1:0] seq_addr;
    wire [PC_WIDTH-1:0] long_skip_addr;
    wire [PC_WIDTH-1:0] short_skip_addr;
    wire [PC_WIDTH-1:0] short_page_addr;
    wire [PC_WIDTH-1:0] short_carry_addr;
    wire [`PCS_PAGE_BITS-1:0] page_now;
    wire [`PCS_PAGE_BITS-1:0] page_next;
    wire at_page_end;
    wire op_call;
    wire op_short_call;
    wire op_sub_ret;
    wire op_int_ret;
    wire op_int_accept;

    // Flat address space: no bank register anywhere
    assign len_ext = {{(PC_WIDTH-2){1'b0}}, i_instr_len};
    assign seq_addr = add_len(program_counter, len_ext);
    assign long_skip_addr = add_len(program_counter,
        `PCS_LONG_BR_LEN);
    // Untaken short branch steps over its own single byte
    assign short_skip_addr = add_len(program_counter,
        `PCS_SHORT_BR_LEN);
    assign page_now = program_counter[PC_WIDTH-1:`PCS_PAGE_LSB];
    // Last of the 64 offsets in a page
    assign at_page_end =
        &program_counter[`PCS_SHORT_BITS-1:0];
    // Page wraps modulo the 2048-byte space
    assign page_next = page_now
        + {{(`PCS_PAGE_BITS-1){1'b0}}, 1'b1};
    assign short_page_addr = page_join(page_now, i_imm_addr);
    assign short_carry_addr = page_join(page_next, i_imm_addr);

    // ========================================================
    // Op decode
    // ========================================================
    // Strobes are gated by i_step; the push address is not,
    // which saves a mux and is harmless while o_push is low
    assign op_call = op_is(i_op, `PCS_OP_CALL);
    assign op_short_call = op_is(i_op, `PCS_OP_SHORT_CALL);
    assign op_sub_ret = op_is(i_op, `PCS_OP_SUB_RET);
    assign op_int_ret = op_is(i_op, `PCS_OP_INT_RET);
    assign op_int_accept = op_is(i_op, `PCS_OP_INT_ACCEPT);

    // ========================================================
    // Next address select
    // ========================================================
    // Hold is the default, so an idle cycle never moves the fetch
    always @*
    begin
        next_program_counter = program_counter;
        if (i_step)
        begin
            case (i_op)
                `PCS_OP_SEQ:
                begin
                    next_program_counter = seq_addr;
                end
                `PCS_OP_LONG_BR:
                begin
                    if (i_branch_condition_flag)
                    begin
                        next_program_counter = i_imm_addr;
                    end
                    else
                    begin
                        next_program_counter = long_skip_addr;
                    end
                end
                `PCS_OP_SHORT_BR:
                begin
                    if (!i_branch_condition_flag)
                    begin
                        next_program_counter = short_skip_addr;
                    end
                    else if (at_page_end)
                    begin
                        next_program_counter = short_carry_addr;
                    end
                    else
                    begin
                        next_program_counter = short_page_addr;
                    end
                end
                `PCS_OP_CALL:
                begin
                    next_program_counter = i_imm_addr;
                end
                `PCS_OP_SHORT_CALL:
                begin
                    next_program_counter =
                        {{`PCS_SCALL_ZERO_BITS{1'b0}},
                        i_short_call_imm};
                end
                `PCS_OP_SUB_RET, `PCS_OP_INT_RET:
                begin
                    next_program_counter = i_stack_addr;
                end
                `PCS_OP_INT_ACCEPT:
                begin
                    next_program_counter =
                        {{(PC_WIDTH-`PCS_VECTOR_WIDTH){1'b0}},
                        i_int_vector};
                end
                // Unreachable with three op bits; steps on safely
                default:
                begin
                    next_program_counter = seq_addr;
                end
            endcase
        end
    end

    // ========================================================
    // Counter register
    // ========================================================
    // Reset loads a constant only, never a feedback value
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            program_counter <= `PCS_PC_RESET;
        end
        else
        begin
            program_counter <= next_program_counter;
        end
    end

    // ========================================================
    // Fetch and stack side
    // ========================================================
    assign o_fetch_addr = program_counter;
    // Call and short_call return past themselves; interrupts resume at the
    // instruction not yet executed, so the counter is saved as is.
    assign o_push = i_step &
        (op_call | op_short_call | op_int_accept);
    assign o_push_flags = i_step & op_int_accept;
    assign o_push_addr = op_int_accept ?
        program_counter : seq_addr;
    // Either return pops exactly one stack entry
    assign o_pop = i_step & (op_sub_ret | op_int_ret);

endmodule // pcs_program_counter_sequencer

// ### verilog/pcs_defines.vh
/*
 * Constants for the program counter sequencer: widths, field
 * positions, reset value and the next-address select codes.
 * Assumes nothing beyond a Verilog-2005 compiler.
 */
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

`define PCS_PC_WIDTH 11
`define PCS_PC_RESET 11'h000
`define PCS_PAGE_LSB 6
`define PCS_PAGE_BITS 5
`define PCS_SHORT_BITS 6
`define PCS_SCALL_ZERO_BITS 3
`define PCS_SCALL_BITS 8
`define PCS_LONG_BR_LEN 11'h002
`define PCS_SHORT_BR_LEN 11'h001
`define PCS_VECTOR_WIDTH 8

`define PCS_OP_SEQ 3'h0
`define PCS_OP_LONG_BR 3'h1
`define PCS_OP_SHORT_BR 3'h2
`define PCS_OP_CALL 3'h3
`define PCS_OP_SHORT_CALL 3'h4
`define PCS_OP_SUB_RET 3'h5
`define PCS_OP_INT_RET 3'h6
`define PCS_OP_INT_ACCEPT 3'h7

`endif

// ### test/pcs_checker_assertions.sv
/* Checker for the sequencer ports. Assumes op codes 0 to 7 as in
   pcs_defines.vh: seq, long, short, call, scall, ret, iret, int. */
`timescale 1ns/10ps
module pcs_checker (
    input wire i_ref_clk, i_resetn, i_step, i_branch_condition_flag,
    input wire [2:0] i_op,
    input wire [1:0] i_instr_len,
    input wire [10:0] i_imm_addr, i_stack_addr, o_fetch_addr, o_push_addr,
    input wire [7:0] i_short_call_imm, i_int_vector,
    input wire o_push, o_push_flags, o_pop
);
    // One-hot of the op taken at this edge
    wire [7:0] s = {7'h0, i_step} << i_op;
    wire [10:0] pc = o_fetch_addr;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    AST_HOLD: assert property (!i_step |=> $stable(pc))
        else $error("pc moved");
    AST_SEQ: assert property (s[0] |=>
        pc == $past(pc) + $past(i_instr_len)) else $error("bad step");
    AST_SKIP: assert property (s[2] && !i_branch_condition_flag |=>
        pc == $past(pc) + 11'h1) else $error("bad short skip");
    AST_JUMP: assert property (s[1] && i_branch_condition_flag |=>
        pc == $past(i_imm_addr)) else $error("bad long branch");
    AST_LONG: assert property (s[1] && !i_branch_condition_flag |=>
        pc == $past(pc) + 11'h2) else $error("bad skip");
    AST_SHORT: assert property (s[2] &&
        i_branch_condition_flag |=>
        pc[5:0] == $past(i_imm_addr[5:0]) &&
        pc[10:6] == $past(pc[10:6]) + ($past(pc[5:0]) == 6'h3f))
        else $error("bad short branch");
    AST_CALL: assert property (s[3] |-> o_push &&
        o_push_addr == pc + i_instr_len ##1 pc == $past(i_imm_addr))
        else $error("bad call");
    AST_SCALL: assert property (s[4] |=>
        pc == {3'h0, $past(i_short_call_imm)}) else $error("bad short call");
    AST_RET: assert property (s[5] || s[6] |-> o_pop ##1
        pc == $past(i_stack_addr)) else $error("bad return");
    AST_INT: assert property (s[7] |-> o_push_flags &&
        o_push_addr == pc ##1 pc == {3'h0, $past(i_int_vector)})
        else $error("bad vector");
endmodule // pcs_checker
bind pcs_program_counter_sequencer pcs_checker u_pcs_checker (.*);

// ### test/pcs_stack_model.sv
/* Return stack model. Assumes push and pop never come together. */
`timescale 1ns/10ps
module pcs_stack_model (
    input wire i_clk, i_rstn, i_push, i_pop,
    input wire [10:0] i_addr,
    output wire [10:0] o_top
);
    reg [10:0] mem [0:15];
    reg [3:0] sp;
    // Empty stack gives a pattern, never a stale entry
    assign o_top = sp == 4'h0 ? 11'h5a5 : mem[sp - 4'h1];
    always @(posedge i_clk or negedge i_rstn)
        if (!i_rstn)
            sp <= 4'h0;
        else if (i_push)
        begin
            mem[sp] <= i_addr;
            sp <= sp + 4'h1;
        end
        // Underflow holds at empty so a stray return reads the pattern
        else if (i_pop && sp != 4'h0)
            sp <= sp - 4'h1;
endmodule // pcs_stack_model

// ### test/tb.sv
/* Random and corner bench for the sequencer. Assumes the stack model. */
`timescale 1ns/10ps
module tb;
    reg clk = 1'b0, rstn = 1'b0, step = 1'b0, flag = 1'b0;
    reg [2:0] op = 3'h0;
    reg [1:0] len = 2'h1;
    reg [10:0] imm = 11'h0, exp = 11'h0;
    reg [7:0] sc = 8'h0, vec = 8'h0;
    wire [10:0] pc, top, pa;
    wire push, pf, pop;
    integer seed = 31, fail_count = 0, cmp_count = 0, n;
    reg [31:0] ro, ra, rf, rs, rr;
    always #10 clk = ~clk;
    pcs_program_counter_sequencer u_pcs_program_counter_sequencer (
        .i_ref_clk(clk), .i_resetn(rstn), .i_step(step), .i_op(op),
        .i_instr_len(len), .i_branch_condition_flag(flag), .i_imm_addr(imm),
        .i_short_call_imm(sc), .i_int_vector(vec), .i_stack_addr(top),
        .o_fetch_addr(pc), .o_push(push), .o_push_flags(pf),
        .o_push_addr(pa), .o_pop(pop));
    pcs_stack_model u_pcs_stack_model (.i_clk(clk), .i_rstn(rstn),
        .i_push(push), .i_pop(pop), .i_addr(pa), .o_top(top));
    function [10:0] nxt(input [10:0] p);
        case (op)
            3'h1: nxt = flag ? imm : p + 11'h2;
            3'h2: nxt = flag ? {p[10:6] + (p[5:0] == 6'h3f), imm[5:0]}
                : p + 11'h1;
            3'h3: nxt = imm;
            3'h4: nxt = {3'h0, sc};
            3'h5, 3'h6: nxt = top;
            3'h7: nxt = {3'h0, vec};
            default: nxt = p + len;
        endcase
    endfunction
    always @(posedge clk or negedge rstn)
        if (!rstn)
            exp <= 11'h0;
        else if (step)
            exp <= nxt(exp);
    task check(input [15:0] got, input [15:0] want);
        begin
            cmp_count = cmp_count + 1;
            if (got !== want || ^got === 1'bx)
            begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, want);
            end
        end
    endtask
    task drive(input [2:0] o, input [10:0] a, input f, input st);
        begin
            @(posedge clk);
            {step, op, imm, flag} <= {st, o, a, f};
            rr = $random(seed);
            {sc, vec, len} <= rr[17:0];
            @(negedge clk);
            check(pc, exp);
            check({push, pop, pf}, {3{step}} & {op == 3'h3 || op == 3'h4 ||
                op == 3'h7, op == 3'h5 || op == 3'h6, op == 3'h7});
            if (push === 1'b1)
                check(pa, op == 3'h7 ? exp : exp + len);
        end
    endtask
    task end_of_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        check(pc, 11'h000);
        drive(3'h3, 11'h03f, 1'b0, 1'b1);
        drive(3'h2, 11'h015, 1'b1, 1'b1);
        drive(3'h2, 11'h02a, 1'b1, 1'b1);
        drive(3'h1, 11'h7ff, 1'b1, 1'b1);
        drive(3'h0, 11'h000, 1'b0, 1'b1);
        drive(3'h5, 11'h000, 1'b0, 1'b0);
        $display("test corner done");
        for (n = 0; n < 2000; n = n + 1)
        begin
            ro = $random(seed);
            ra = $random(seed);
            rf = $random(seed);
            rs = $random(seed);
            drive(ro[2:0], ra[10:0], rf[0],
                rs[2:0] != 3'h0);
        end
        // Let the last random step land before reset hits
        @(posedge clk);
        step <= 1'b0;
        @(negedge clk);
        check(pc, exp);
        $display("test random done");
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        check(pc, 11'h000);
        @(posedge clk);
        rstn <= 1'b1;
        drive(3'h0, 11'h000, 1'b0, 1'b1);
        drive(3'h0, 11'h000, 1'b0, 1'b0);
        $display("test reset done");
        end_of_test;
    end
    initial
    begin
        #100000;
        fail_count = fail_count + 1;
        end_of_test;
    end
endmodule // tb
